// >>> verilog/ccs_params.svh
// register offsets, field positions and reset values of the capture control bank
// assumes a 12-bit byte offset from the register base
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// byte offsets
`define CCS_OFF_FORMAT    12'h608
`define CCS_OFF_CONT      12'h614
`define CCS_OFF_SAVE      12'h618
`define CCS_OFF_SINGLE    12'h61C
`define CCS_OFF_SAVE_CH   12'h620
`define CCS_OFF_LOAD_CH   12'h624
`define CCS_OFF_WORK_CFG  12'h640

// field positions
`define CCS_FMT_MSB       2
`define CCS_CH_MSB        3
`define CCS_CTL_BIT       0

// video formats under which transmission controls act
`define CCS_FMT_STD0      3'h0
`define CCS_FMT_SCAL      3'h7

// reset values
`define CCS_FMT_RST       3'h7
`define CCS_CONT_RST      1'h0
`define CCS_SINGLE_RST    1'h0
`define CCS_SAVE_RST      1'h0
`define CCS_SAVE_CH_RST   4'h1
`define CCS_LAST_CH_RST   4'h0

`endif

// >>> verilog/ccs_pkg.sv
// types shared by the capture control bank and its users
// assumes the register offsets come from ccs_params.svh
package ccs_pkg;

    // one register request, one cycle long
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ccs_bus_req_t;

    // controls toward the frame transmitter
    typedef struct packed {
        logic stream_enable;
        logic single_req;
    } ccs_tx_t;

endpackage

// >>> verilog/ccs_top.sv
// capture control and configuration store: transmission controls, save/load of
// the working configuration set to numbered memory channels
// assumes a single-cycle register master and a transmitter that pulses frame_done
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "ccs_params.svh"

module ccs_top #(
    parameter int                 CFG_W    = 32,
    parameter int                 CHAN_N   = 4,
    parameter logic [CFG_W-1:0]   FACT_CFG = '0
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // register port
    input  wire ccs_pkg::ccs_bus_req_t bus_req,
    output      logic [31:0]         rd_data,
    // frame transmitter
    input  wire logic                frame_done,
    output      ccs_pkg::ccs_tx_t    tx_ctrl,
    // configuration outputs
    output      logic [CFG_W-1:0]    work_cfg,
    output      logic [2:0]          video_format
);
    import ccs_pkg::*;

    localparam int         CH_IW  = (CHAN_N > 1) ? $clog2(CHAN_N) : 1;
    localparam logic [3:0] CH_MAX = 4'(CHAN_N - 1);

    logic              cont_q;
    logic              single_q;
    logic              save_q;
    logic [3:0]        save_ch_q;
    logic [3:0]        last_ch_q;
    logic [CFG_W-1:0]  chan_mem [CHAN_N];

    // address decode
    wire logic hit_fmt     = bus_req.addr == `CCS_OFF_FORMAT;
    wire logic hit_cont    = bus_req.addr == `CCS_OFF_CONT;
    wire logic hit_save    = bus_req.addr == `CCS_OFF_SAVE;
    wire logic hit_single  = bus_req.addr == `CCS_OFF_SINGLE;
    wire logic hit_save_ch = bus_req.addr == `CCS_OFF_SAVE_CH;
    wire logic hit_load_ch = bus_req.addr == `CCS_OFF_LOAD_CH;
    wire logic hit_work    = bus_req.addr == `CCS_OFF_WORK_CFG;

    wire logic wr_fmt      = bus_req.wr && hit_fmt;
    wire logic wr_cont     = bus_req.wr && hit_cont;
    wire logic wr_save     = bus_req.wr && hit_save;
    wire logic wr_single   = bus_req.wr && hit_single;
    wire logic wr_save_ch  = bus_req.wr && hit_save_ch;
    wire logic wr_load_ch  = bus_req.wr && hit_load_ch;
    wire logic wr_work     = bus_req.wr && hit_work;
    wire logic wr_bit0     = bus_req.wdata[`CCS_CTL_BIT];

    wire logic [3:0] wr_ch = bus_req.wdata[`CCS_CH_MSB:0];

    // transmission controls only act in these two formats
    wire logic fmt_ok = (video_format == `CCS_FMT_STD0) ||
                        (video_format == `CCS_FMT_SCAL);

    // channel 0 holds factory settings, so it is never a save target
    wire logic save_ok = (save_ch_q != 4'h0) && (save_ch_q <= CH_MAX);
    wire logic load_ok = wr_ch <= CH_MAX;

    wire logic [CH_IW-1:0] save_idx = save_ch_q[CH_IW-1:0];
    wire logic [CH_IW-1:0] load_idx = wr_ch[CH_IW-1:0];

    // a request that lands with frame_done wins, so no request is lost
    wire logic next_single = (wr_single && wr_bit0 && fmt_ok) ? 1'b1 :
                             (frame_done ? 1'b0 : single_q);

    // the save bit stands one cycle, the cycle the copy happens
    wire logic next_save = wr_save && wr_bit0;

    wire ccs_tx_t next_tx = '{stream_enable: cont_q && fmt_ok,
                              single_req:    single_q && fmt_ok};

    // read selection; bits 1..31 of the single frame word always read zero
    wire logic [31:0] rd_fmt     = {29'h0, video_format};
    wire logic [31:0] rd_cont    = {31'h0, cont_q};
    wire logic [31:0] rd_save    = {31'h0, save_q};
    wire logic [31:0] rd_single  = {31'h0, single_q};
    wire logic [31:0] rd_save_ch = {28'h0, save_ch_q};
    wire logic [31:0] rd_load_ch = {28'h0, last_ch_q};
    wire logic [31:0] rd_work    = 32'(work_cfg);

    wire logic [31:0] rd_mux = hit_fmt     ? rd_fmt     :
                               hit_cont    ? rd_cont    :
                               hit_save    ? rd_save    :
                               hit_single  ? rd_single  :
                               hit_save_ch ? rd_save_ch :
                               hit_load_ch ? rd_load_ch :
                               hit_work    ? rd_work    : 32'h0;

    wire logic [31:0] next_rd_data = bus_req.rd ? rd_mux : 32'h0;

    // control registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            video_format <= `CCS_FMT_RST;
            cont_q       <= `CCS_CONT_RST;
            single_q     <= `CCS_SINGLE_RST;
            save_q       <= `CCS_SAVE_RST;
            save_ch_q    <= `CCS_SAVE_CH_RST;
        end else begin
            if (wr_fmt) begin
                video_format <= bus_req.wdata[`CCS_FMT_MSB:0];
            end
            if (wr_cont) begin
                cont_q <= wr_bit0;
            end
            if (wr_save_ch) begin
                save_ch_q <= wr_ch;
            end
            single_q <= next_single;
            save_q   <= next_save;
        end
    end

    // working set and last loaded channel
    always_ff @(posedge clk) begin
        if (!nrst) begin
            work_cfg  <= FACT_CFG;
            last_ch_q <= `CCS_LAST_CH_RST;
        end else if (wr_load_ch && load_ok) begin
            work_cfg  <= chan_mem[load_idx];
            last_ch_q <= wr_ch;
        end else if (wr_work) begin
            work_cfg <= bus_req.wdata[CFG_W-1:0];
        end
    end

    // channel store; the copy uses the working set as it stands that cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < CHAN_N; i++) begin
                chan_mem[i] <= FACT_CFG;
            end
        end else if (save_q && save_ok) begin
            chan_mem[save_idx] <= work_cfg;
        end
    end

    // outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_ctrl <= '0;
            rd_data <= 32'h0;
        end else begin
            tx_ctrl <= next_tx;
            rd_data <= next_rd_data;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_cont_start;
        wr_cont && wr_bit0 && fmt_ok
            |-> ##2 (tx_ctrl.stream_enable || !$past(fmt_ok));
    endproperty
    a_cont_start: assert property (p_cont_start)
        else $error("continuous transmission did not start");

    property p_cont_gate;
        !fmt_ok |=> !tx_ctrl.stream_enable && !tx_ctrl.single_req;
    endproperty
    a_cont_gate: assert property (p_cont_gate)
        else $error("transmission active outside format 0 or 7");

    property p_single_set;
        wr_single && wr_bit0 && fmt_ok |=> single_q ##1 tx_ctrl.single_req || !$past(fmt_ok);
    endproperty
    a_single_set: assert property (p_single_set)
        else $error("single frame request not raised");

    property p_single_blocked;
        wr_single && !single_q && !fmt_ok |=> !single_q;
    endproperty
    a_single_blocked: assert property (p_single_blocked)
        else $error("single frame accepted in wrong format");

    property p_single_clear;
        single_q && frame_done && !(wr_single && wr_bit0) |=> !single_q;
    endproperty
    a_single_clear: assert property (p_single_clear)
        else $error("single frame bit not cleared after frame");

    property p_multi_zero;
        bus_req.rd && hit_single |=> rd_data[31:1] == 31'h0;
    endproperty
    a_multi_zero: assert property (p_multi_zero)
        else $error("multiple frame bits read nonzero");

    property p_save_copy;
        save_q && save_ok |=> chan_mem[$past(save_idx)] == $past(work_cfg);
    endproperty
    a_save_copy: assert property (p_save_copy)
        else $error("save did not copy working set");

    property p_save_self_clear;
        wr_save && wr_bit0 |=> save_q ##1 (!save_q || $past(wr_save && wr_bit0));
    endproperty
    a_save_self_clear: assert property (p_save_self_clear)
        else $error("save bit did not self clear");

    property p_load_copy;
        wr_load_ch && load_ok
            |=> work_cfg == $past(chan_mem[load_idx]) && last_ch_q == $past(wr_ch);
    endproperty
    a_load_copy: assert property (p_load_copy)
        else $error("load did not copy channel");

    property p_load_bad;
        wr_load_ch && !load_ok |=> $stable(work_cfg) && $stable(last_ch_q);
    endproperty
    a_load_bad: assert property (p_load_bad)
        else $error("invalid load changed state");

    // every channel, not just the low ones, must survive a bad or foreign save
    for (genvar g = 0; g < CHAN_N; g++) begin : g_save_chk
        property p_save_bad;
            !(save_q && save_ok && save_idx == CH_IW'(g)) |=> $stable(chan_mem[g]);
        endproperty
        a_save_bad: assert property (p_save_bad)
            else $error("invalid save changed a channel");
    end

    property p_load_read;
        bus_req.rd && hit_load_ch |=> rd_data == {28'h0, $past(last_ch_q)};
    endproperty
    a_load_read: assert property (p_load_read)
        else $error("load register read wrong channel");

    property p_fmt_write;
        wr_fmt |=> video_format == $past(bus_req.wdata[`CCS_FMT_MSB:0]);
    endproperty
    a_fmt_write: assert property (p_fmt_write)
        else $error("format write not taken");

    property p_fmt_hold;
        !wr_fmt |=> $stable(video_format);
    endproperty
    a_fmt_hold: assert property (p_fmt_hold)
        else $error("format changed without a write");

    property p_cont_stop;
        wr_cont && !wr_bit0
            |-> ##2 !tx_ctrl.stream_enable;
    endproperty
    a_cont_stop: assert property (p_cont_stop)
        else $error("continuous transmission did not stop");

    property p_cont_hold;
        !wr_cont |=> $stable(cont_q);
    endproperty
    a_cont_hold: assert property (p_cont_hold)
        else $error("continuous bit changed without a write");

    property p_single_nop;
        wr_single && !wr_bit0 && !frame_done |=> single_q == $past(single_q);
    endproperty
    a_single_nop: assert property (p_single_nop)
        else $error("multiple frame bits changed the request");

    property p_single_hold;
        single_q && !frame_done |=> single_q;
    endproperty
    a_single_hold: assert property (p_single_hold)
        else $error("single frame bit dropped before frame end");

    property p_single_idle;
        !single_q && !(wr_single && wr_bit0) |=> !single_q;
    endproperty
    a_single_idle: assert property (p_single_idle)
        else $error("single frame bit rose without a write");

    property p_single_gate_out;
        single_q && fmt_ok |=> tx_ctrl.single_req;
    endproperty
    a_single_gate_out: assert property (p_single_gate_out)
        else $error("single frame request not passed on");

    // one frame per request: the request must be gone two cycles after frame end
    property p_single_once;
        tx_ctrl.single_req && frame_done && !(wr_single && wr_bit0)
            |-> ##2 !tx_ctrl.single_req;
    endproperty
    a_single_once: assert property (p_single_once)
        else $error("single frame request outlived its frame");

    property p_single_read;
        bus_req.rd && hit_single |=> rd_data[0] == $past(single_q);
    endproperty
    a_single_read: assert property (p_single_read)
        else $error("single frame bit read wrong");

    property p_save_only;
        !(wr_save && wr_bit0) |=> !save_q;
    endproperty
    a_save_only: assert property (p_save_only)
        else $error("save bit set without a write");

    property p_save_read;
        bus_req.rd && hit_save |=> rd_data == {31'h0, $past(save_q)};
    endproperty
    a_save_read: assert property (p_save_read)
        else $error("save bit read wrong");

    property p_save_ch_write;
        wr_save_ch |=> save_ch_q == $past(wr_ch);
    endproperty
    a_save_ch_write: assert property (p_save_ch_write)
        else $error("save channel write not taken");

    property p_save_ch_hold;
        !wr_save_ch |=> $stable(save_ch_q);
    endproperty
    a_save_ch_hold: assert property (p_save_ch_hold)
        else $error("save channel changed without a write");

    property p_last_hold;
        !(wr_load_ch && load_ok) |=> $stable(last_ch_q);
    endproperty
    a_last_hold: assert property (p_last_hold)
        else $error("last channel changed without a load");

    // only accepted loads reach the last channel, so a read never shows a bad one
    property p_last_range;
        bus_req.rd && hit_load_ch |=> rd_data[31:4] == 28'h0 && rd_data[3:0] <= CH_MAX;
    endproperty
    a_last_range: assert property (p_last_range)
        else $error("last channel read out of range");

endmodule // ccs_top

// >>> bench/tb_capture_control_and_config_store.sv
// self-checking bench for the capture control bank
// assumes ccs_pkg and ccs_params.svh are compiled and on the include path
`timescale 1ns/1ps
`include "ccs_params.svh"

module tb_capture_control_and_config_store;
    import ccs_pkg::*;
    localparam logic [31:0] FACT = 32'hA5A5_0F0F;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    ccs_bus_req_t bus_req = '0;
    logic         frame_done = 1'b0;
    logic [31:0]  rd_data;
    ccs_tx_t      tx_ctrl;
    logic [31:0]  work_cfg;
    logic [2:0]   video_format;
    logic [31:0]  seed = 32'h2C;
    logic [31:0]  model [4];
    logic [31:0]  v;
    logic [31:0]  c;
    int           n_mismatch = 0;
    int           n_compared = 0;
    int           cyc = 0;

    always #2 clk = ~clk;

    ccs_top #(.CFG_W(32), .CHAN_N(4), .FACT_CFG(FACT)) i_dut (
        .clk(clk), .nrst(nrst), .bus_req(bus_req), .rd_data(rd_data),
        .frame_done(frame_done), .tx_ctrl(tx_ctrl), .work_cfg(work_cfg),
        .video_format(video_format));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] gate(input logic [2:0] f);
        return 32'((f == `CCS_FMT_STD0) || (f == `CCS_FMT_SCAL));
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 chk(nm, e, rd_data);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // run length is under two hundred cycles; ceiling leaves wide margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(`CCS_OFF_FORMAT, 32'h7, "format");
        rd(`CCS_OFF_CONT, 32'h0, "cont");
        rd(`CCS_OFF_SINGLE, 32'h0, "single");
        rd(`CCS_OFF_LOAD_CH, 32'h0, "last_ch");
        rd(12'h700, 32'h0, "unmapped");
        settle(1);
        chk("rd_idle", 32'h0, rd_data);
        chk("work_rst", FACT, work_cfg);
        // multi-frame bits and count ride along and must be dropped
        wr(`CCS_OFF_SINGLE, 32'hFFFF_0003);
        rd(`CCS_OFF_SINGLE, 32'h1, "single_rb");
        wr(`CCS_OFF_CONT, 32'h1);
        for (int f = 0; f < 8; f++) begin
            wr(`CCS_OFF_FORMAT, 32'(f));
            settle(1);
            chk("fmt", 32'(f), 32'(video_format));
            chk("stream", gate(3'(f)), 32'(tx_ctrl.stream_enable));
            chk("one", gate(3'(f)), 32'(tx_ctrl.single_req));
        end
        @(posedge clk);
        frame_done <= 1'b1;
        @(posedge clk);
        frame_done <= 1'b0;
        settle(1);
        chk("one_done", 32'h0, 32'(tx_ctrl.single_req));
        rd(`CCS_OFF_SINGLE, 32'h0, "single_clr");
        chk("stream_on", 32'h1, 32'(tx_ctrl.stream_enable));
        wr(`CCS_OFF_CONT, 32'h0);
        settle(1);
        chk("stream_off", 32'h0, 32'(tx_ctrl.stream_enable));
        wr(`CCS_OFF_SINGLE, 32'hFFFF_0002);
        rd(`CCS_OFF_SINGLE, 32'h0, "single_nop");
        wr(`CCS_OFF_FORMAT, 32'h3);
        wr(`CCS_OFF_SINGLE, 32'h1);
        rd(`CCS_OFF_SINGLE, 32'h0, "single_fmt3");
        settle(0);
        chk("one_fmt3", 32'h0, 32'(tx_ctrl.single_req));
        wr(`CCS_OFF_FORMAT, 32'h7);
        // request and frame end in one cycle: the request must survive
        @(posedge clk);
        bus_req <= '{addr: `CCS_OFF_SINGLE, wdata: 32'h1, wr: 1'b1, rd: 1'b0};
        frame_done <= 1'b1;
        @(posedge clk);
        bus_req.wr <= 1'b0;
        frame_done <= 1'b0;
        rd(`CCS_OFF_SINGLE, 32'h1, "single_win");
        model = '{FACT, FACT, FACT, FACT};
        for (int i = 0; i < 8; i++) begin
            v = xs();
            c = xs() % 3 + 1;
            wr(`CCS_OFF_WORK_CFG, v);
            wr(`CCS_OFF_SAVE_CH, c);
            wr(`CCS_OFF_SAVE, 32'h1);
            model[c[1:0]] = v;
            rd(`CCS_OFF_SAVE, 32'h0, "save_clr");
        end
        // saves to channel 0 and past the last channel leave all untouched
        wr(`CCS_OFF_SAVE_CH, 32'h0);
        wr(`CCS_OFF_SAVE, 32'h1);
        wr(`CCS_OFF_SAVE_CH, 32'h4);
        wr(`CCS_OFF_SAVE, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wr(`CCS_OFF_LOAD_CH, 32'(k));
            settle(0);
            chk("load", model[k], work_cfg);
            rd(`CCS_OFF_LOAD_CH, 32'(k), "last");
        end
        wr(`CCS_OFF_LOAD_CH, 32'hE);
        settle(0);
        chk("load_bad", model[3], work_cfg);
        rd(`CCS_OFF_LOAD_CH, 32'h3, "last_bad");
        results();
    end
endmodule // tb_capture_control_and_config_store
